// >>> src/abx_exec.sv
// Decode and execute unit for add, and, equal-branch and link-branch forms
`timescale 1ns/10ps
`default_nettype none
module abx_exec
   import abx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        instr_valid,
   input  wire logic [31:0] instr_word,
   input  wire logic [31:0] instr_pc,
   input  wire logic [4:0]  dbg_rd_addr,
   output logic      [31:0] dbg_rd_data,
   output logic             done,
   output logic             ovf_exc,
   output logic [31:0]      exc_pc,
   output logic             redirect,
   output logic [31:0]      redirect_pc,
   output logic             nullify_slot,
   output logic             illegal,
   output logic             wb_en,
   output logic [4:0]       wb_addr,
   output logic [31:0]      wb_data
);
   typedef enum logic [1:0] {
      ABX_S_IDLE, ABX_S_READ, ABX_S_EXEC
   } abx_state_t;

   // Sign-extended 18-bit branch offset
   function automatic logic [31:0] abx_boff(input logic [15:0] ofs);
      abx_boff = {{14{ofs[15]}}, ofs, 2'b00};
   endfunction

   // Sign-extended immediate
   function automatic logic [31:0] abx_sext(input logic [15:0] imm);
      abx_sext = {{16{imm[15]}}, imm};
   endfunction

   abx_state_t  state;
   abx_state_t  next_state;
   abx_kind_t   kind;
   abx_kind_t   next_kind;
   logic [31:0] iw;
   logic [31:0] next_iw;
   logic [31:0] ipc;
   logic [31:0] next_ipc;
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [4:0]  rf_ra;
   logic [4:0]  rf_rb;
   abx_kind_t   dec_kind;

   logic        next_done;
   logic        next_ovf_exc;
   logic [31:0] next_exc_pc;
   logic        next_redirect;
   logic [31:0] next_redirect_pc;
   logic        next_nullify_slot;
   logic        next_illegal;
   logic        next_wb_en;
   logic [4:0]  next_wb_addr;
   logic [31:0] next_wb_data;
   logic        rf_we;
   logic [4:0]  rf_wa;
   logic [31:0] rf_wd;
   logic [32:0] sum_ext;

   // Decode of the incoming word
   always_comb begin
      logic [5:0] op;
      logic [5:0] fn;
      op = instr_word[ABX_OP_HI:ABX_OP_LO];
      fn = instr_word[ABX_FN_HI:0];
      dec_kind = ABX_K_NONE;
      unique case (op)
         ABX_OP_ADDIT: dec_kind = ABX_K_ADDIT;
         ABX_OP_ADDIM: dec_kind = ABX_K_ADDIM;
         ABX_OP_BITAND_IMM: dec_kind = ABX_K_BITAND_IMM;
         ABX_OP_BEQ: dec_kind = ABX_K_BEQ;
         ABX_OP_BRANCH_IF_EQUAL_LIKELY: dec_kind = ABX_K_BRANCH_IF_EQUAL_LIKELY;
         ABX_OP_SPECIAL: begin
            if (instr_word[ABX_SH_HI:ABX_SH_LO] == 5'h00) begin
               if (fn == ABX_FN_ADDRM)
                  dec_kind = ABX_K_ADDRM;
               else if (fn == ABX_FN_AND)
                  dec_kind = ABX_K_AND;
            end
         end
         ABX_OP_CLASS_A: begin
            if (instr_word[ABX_RB_HI:ABX_RB_LO] == ABX_RB_NNLINK &&
                instr_word[ABX_RA_HI:ABX_RA_LO] == ABX_REG_ZERO)
               dec_kind = ABX_K_BAL;
         end
         default: dec_kind = ABX_K_NONE;
      endcase
   end

   // Sequencer: take word, read operands, execute
   always_comb begin
      next_state = state;
      next_kind  = kind;
      next_iw    = iw;
      next_ipc   = ipc;
      unique case (state)
         ABX_S_IDLE: begin
            if (instr_valid) begin
               next_state = ABX_S_READ;
               next_kind  = dec_kind;
               next_iw    = instr_word;
               next_ipc   = instr_pc;
            end
         end
         ABX_S_READ: next_state = ABX_S_EXEC;
         ABX_S_EXEC: next_state = ABX_S_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ABX_S_IDLE;
         kind  <= ABX_K_NONE;
         iw    <= ABX_WORD_ZERO;
         ipc   <= ABX_PC_RESET;
      end else begin
         state <= next_state;
         kind  <= next_kind;
         iw    <= next_iw;
         ipc   <= next_ipc;
      end
   end

   // Port A reads the latched source; in idle it serves the debug view
   assign rf_ra   = (state == ABX_S_IDLE) ? dbg_rd_addr :
                    iw[ABX_RA_HI:ABX_RA_LO];
   assign rf_rb   = iw[ABX_RB_HI:ABX_RB_LO];
   assign sum_ext = {op_a[31], op_a} + {op_b[31], op_b};

   abx_regfile #(
      .WIDTH (ABX_XLEN),
      .DEPTH (ABX_NREG)
   ) u_rf (
      .clk       (clk),
      .rst_n     (rst_n),
      .rd_addr_a (rf_ra),
      .rd_addr_b (rf_rb),
      .rd_data_a (op_a),
      .rd_data_b (op_b),
      .wr_en     (rf_we),
      .wr_addr   (rf_wa),
      .wr_data   (rf_wd)
   );

   assign rf_we = wb_en;
   assign rf_wa = wb_addr;
   assign rf_wd = wb_data;

   // Execute stage results
   always_comb begin
      logic [31:0] slot_pc;
      logic [31:0] imm_s;
      logic [31:0] b_src;
      slot_pc = ipc + ABX_SLOT_OFS;
      imm_s   = abx_sext(iw[ABX_IMM_HI:0]);
      b_src   = op_b;
      next_done         = 1'b0;
      next_ovf_exc      = 1'b0;
      next_exc_pc       = exc_pc;
      next_redirect     = 1'b0;
      next_redirect_pc  = redirect_pc;
      next_nullify_slot = 1'b0;
      next_illegal      = 1'b0;
      next_wb_en        = 1'b0;
      next_wb_addr      = wb_addr;
      next_wb_data      = wb_data;
      if (state == ABX_S_EXEC) begin
         next_done = 1'b1;
         next_redirect_pc = slot_pc + abx_boff(iw[ABX_IMM_HI:0]);
         unique case (kind)
            ABX_K_ADDIT: begin
               next_wb_data = op_a + imm_s;
               if (op_a[31] == imm_s[31] && next_wb_data[31] != op_a[31]) begin
                  next_ovf_exc = 1'b1;
                  next_exc_pc  = ipc;
               end else begin
                  next_wb_en   = 1'b1;
                  next_wb_addr = iw[ABX_RB_HI:ABX_RB_LO];
               end
            end
            ABX_K_ADDIM: begin
               next_wb_en   = 1'b1;
               next_wb_addr = iw[ABX_RB_HI:ABX_RB_LO];
               next_wb_data = op_a + imm_s;
            end
            ABX_K_ADDRM: begin
               next_wb_en   = 1'b1;
               next_wb_addr = iw[ABX_RD_HI:ABX_RD_LO];
               next_wb_data = sum_ext[31:0];
            end
            ABX_K_AND: begin
               next_wb_en   = 1'b1;
               next_wb_addr = iw[ABX_RD_HI:ABX_RD_LO];
               next_wb_data = op_a & b_src;
            end
            ABX_K_BITAND_IMM: begin
               next_wb_en   = 1'b1;
               next_wb_addr = iw[ABX_RB_HI:ABX_RB_LO];
               next_wb_data = op_a & {16'h0000, iw[ABX_IMM_HI:0]};
            end
            ABX_K_BEQ: next_redirect = (op_a == op_b);
            ABX_K_BRANCH_IF_EQUAL_LIKELY: begin
               next_redirect     = (op_a == op_b);
               next_nullify_slot = (op_a != op_b);
            end
            ABX_K_BAL: begin
               next_redirect = 1'b1;
               next_wb_en    = 1'b1;
               next_wb_addr  = ABX_REG_LINK;
               next_wb_data  = ipc + ABX_LINK_OFS;
            end
            ABX_K_NONE: next_illegal = 1'b1;
            default: next_illegal = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done         <= 1'b0;
         ovf_exc      <= 1'b0;
         exc_pc       <= ABX_PC_RESET;
         redirect     <= 1'b0;
         redirect_pc  <= ABX_PC_RESET;
         nullify_slot <= 1'b0;
         illegal      <= 1'b0;
         wb_en        <= 1'b0;
         wb_addr      <= ABX_REG_ZERO;
         wb_data      <= ABX_WORD_ZERO;
         dbg_rd_data  <= ABX_WORD_ZERO;
      end else begin
         done         <= next_done;
         ovf_exc      <= next_ovf_exc;
         exc_pc       <= next_exc_pc;
         redirect     <= next_redirect;
         redirect_pc  <= next_redirect_pc;
         nullify_slot <= next_nullify_slot;
         illegal      <= next_illegal;
         wb_en        <= next_wb_en;
         wb_addr      <= next_wb_addr;
         wb_data      <= next_wb_data;
         dbg_rd_data  <= op_a;
      end
   end

   chk_ovf_no_write: assert property (@(posedge clk) disable iff (!rst_n)
      ovf_exc |-> !wb_en) else $error("overflow with register write");
   chk_modulo_no_trap: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ABX_S_EXEC && kind != ABX_K_ADDIT) |=> !ovf_exc)
      else $error("non-trapping form raised overflow");
   chk_addit_timing: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ABX_S_IDLE && instr_valid && dec_kind == ABX_K_ADDIT)
      |=> ##2 (done && (ovf_exc || wb_en)))
      else $error("trapping add gave no result");
   chk_addit_target: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ABX_S_EXEC && kind == ABX_K_ADDIT) |=>
      (wb_en |-> wb_addr == $past(iw[ABX_RB_HI:ABX_RB_LO])))
      else $error("trapping add wrote wrong register");
   chk_link_value: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ABX_S_EXEC && kind == ABX_K_BAL) |=>
      (wb_en && redirect && wb_addr == ABX_REG_LINK &&
       wb_data == $past(ipc) + ABX_LINK_OFS))
      else $error("link branch wrong");
   chk_branch_target: assert property (@(posedge clk) disable iff (!rst_n)
      redirect |-> redirect_pc == ipc + ABX_SLOT_OFS +
      {{14{iw[15]}}, iw[15:0], 2'b00})
      else $error("branch target wrong");
   // likely nullifies exactly when not taken
   chk_likely_null: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ABX_S_EXEC && kind == ABX_K_BRANCH_IF_EQUAL_LIKELY) |=>
      (redirect != nullify_slot))
      else $error("likely branch slot handling wrong");
   chk_beq_slot: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ABX_S_EXEC && kind == ABX_K_BEQ) |=>
      (!nullify_slot && redirect == $past(op_a == op_b)))
      else $error("equal branch wrong");
   chk_zero_reg: assert property (@(posedge clk) disable iff (!rst_n)
      (state == ABX_S_READ && iw[ABX_RA_HI:ABX_RA_LO] == ABX_REG_ZERO)
      |=> op_a == ABX_WORD_ZERO)
      else $error("register zero not zero");
endmodule
`default_nettype wire

// >>> pkg/abx_pkg.sv
// Package of encodings and field positions for the add, and, branch unit
package abx_pkg;
   localparam int          ABX_XLEN       = 32;
   localparam int          ABX_NREG       = 32;
   localparam int          ABX_OP_HI      = 31;
   localparam int          ABX_OP_LO      = 26;
   localparam int          ABX_RA_HI      = 25;
   localparam int          ABX_RA_LO      = 21;
   localparam int          ABX_RB_HI      = 20;
   localparam int          ABX_RB_LO      = 16;
   localparam int          ABX_RD_HI      = 15;
   localparam int          ABX_RD_LO      = 11;
   localparam int          ABX_SH_HI      = 10;
   localparam int          ABX_SH_LO      = 6;
   localparam int          ABX_FN_HI      = 5;
   localparam int          ABX_IMM_HI     = 15;
   localparam logic [5:0]  ABX_OP_SPECIAL = 6'h00;
   localparam logic [5:0]  ABX_OP_CLASS_A = 6'h01;
   localparam logic [5:0]  ABX_OP_ADDIT   = 6'h08;
   localparam logic [5:0]  ABX_OP_ADDIM   = 6'h09;
   localparam logic [5:0]  ABX_OP_BITAND_IMM    = 6'h0c;
   localparam logic [5:0]  ABX_OP_BEQ     = 6'h04;
   localparam logic [5:0]  ABX_OP_BRANCH_IF_EQUAL_LIKELY    = 6'h14;
   localparam logic [5:0]  ABX_FN_ADDRM   = 6'h21;
   localparam logic [5:0]  ABX_FN_AND     = 6'h24;
   localparam logic [4:0]  ABX_RB_NNLINK  = 5'h11;
   localparam logic [4:0]  ABX_REG_ZERO   = 5'h00;
   localparam logic [4:0]  ABX_REG_LINK   = 5'h1f;
   localparam logic [31:0] ABX_LINK_OFS   = 32'h00000008;
   localparam logic [31:0] ABX_SLOT_OFS   = 32'h00000004;
   localparam logic [31:0] ABX_PC_RESET   = 32'h00000000;
   localparam logic [31:0] ABX_WORD_ZERO  = 32'h00000000;

   typedef enum logic [3:0] {
      ABX_K_NONE, ABX_K_ADDIT, ABX_K_ADDIM, ABX_K_ADDRM, ABX_K_AND,
      ABX_K_BITAND_IMM, ABX_K_BEQ, ABX_K_BRANCH_IF_EQUAL_LIKELY, ABX_K_BAL
   } abx_kind_t;
endpackage

// >>> src/abx_regfile.sv
// General register file with two registered read ports, one write port
`timescale 1ns/10ps
`default_nettype none
module abx_regfile
   import abx_pkg::*;
#(
   parameter int WIDTH = ABX_XLEN,
   parameter int DEPTH = ABX_NREG
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_a,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_b,
   output logic      [WIDTH-1:0]         rd_data_a,
   output logic      [WIDTH-1:0]         rd_data_b,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data
);
   localparam int AW = $clog2(DEPTH);
   // Refuse shapes that the address decode cannot serve
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_shape
      $error("abx_regfile: DEPTH must be a power of two, WIDTH >= 1");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_rd_data_a;
   logic [WIDTH-1:0] next_rd_data_b;

   // Read data; register zero always reads as zero
   // zero register read
   always_comb begin
      next_rd_data_a = (rd_addr_a == '0) ? '0 : mem[rd_addr_a];
      next_rd_data_b = (rd_addr_b == '0) ? '0 : mem[rd_addr_b];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_a <= '0;
         rd_data_b <= '0;
      end else begin
         rd_data_a <= next_rd_data_a;
         rd_data_b <= next_rd_data_b;
      end
   end

   // Storage; writes to register zero are dropped
   // zero write discard
   always_ff @(posedge clk) begin
      if (wr_en && wr_addr != '0) begin
         mem[wr_addr] <= wr_data;
      end
   end
endmodule
`default_nettype wire

// >>> tb/abx_fetch_model.sv
// Fetch-side partner model handing one instruction word at a time to the unit
`timescale 1ns/10ps
`default_nettype none
module abx_fetch_model
   import abx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        done,
   output logic             instr_valid,
   output logic [31:0]      instr_word,
   output logic [31:0]      instr_pc
);
   int lat; // Negedges waited for completion

   // Quiet bus at time zero
   initial begin
      instr_valid = 1'b0;
      instr_word  = 32'h00000000;
      instr_pc    = 32'h00000000;
      lat         = 0;
   end

   // Hands over one word after gap idle cycles, then waits for done
   task automatic issue(input logic [31:0] word, input logic [31:0] pc,
                        input int gap);
      for (int i = 0; i < gap; i++) @(negedge clk);
      // no branch in a slot, no r31 link source
      instr_valid = 1'b1;
      instr_word  = word;
      instr_pc    = pc;
      @(negedge clk);
      // Released lines show the inverse so stale values never match
      instr_valid = 1'b0;
      instr_word  = ~word;
      instr_pc    = ~pc;
      lat         = 1;
      while (done !== 1'b1 && lat < 10) begin
         @(negedge clk);
         lat++;
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the add, and and branch execute unit
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import abx_pkg::*;
;
   localparam logic [4:0] F_WB  = 5'h10;
   localparam logic [4:0] F_OVF = 5'h08;
   localparam logic [4:0] F_RED = 5'h04;
   localparam logic [4:0] F_NUL = 5'h02;
   localparam logic [4:0] F_ILL = 5'h01;
   logic        clk;
   logic        rst_n;
   logic        instr_valid;
   logic [31:0] instr_word;
   logic [31:0] instr_pc;
   logic [4:0]  dbg_rd_addr;
   logic [31:0] dbg_rd_data;
   logic        done;
   logic        ovf_exc;
   logic [31:0] exc_pc;
   logic        redirect;
   logic [31:0] redirect_pc;
   logic        nullify_slot;
   logic        illegal;
   logic        wb_en;
   logic [4:0]  wb_addr;
   logic [31:0] wb_data;
   logic [31:0] exp_reg [32];
   logic [31:0] cur_pc;
   int          num_errors;
   int          n_compared;

   abx_exec dut (.clk, .rst_n, .instr_valid, .instr_word, .instr_pc,
      .dbg_rd_addr, .dbg_rd_data, .done, .ovf_exc, .exc_pc, .redirect,
      .redirect_pc, .nullify_slot, .illegal, .wb_en, .wb_addr, .wb_data);
   abx_fetch_model fetch (.clk, .done, .instr_valid, .instr_word,
      .instr_pc);

   // Free-running 100 MHz clock
   always #5 clk = ~clk;

   // Ends the run with counts and verdict
   task automatic report_and_stop();
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [31:0] fi(input logic [5:0] op,
      input logic [4:0] ra, input logic [4:0] rb, input logic [15:0] im);
      return {op, ra, rb, im};
   endfunction

   function automatic logic [31:0] fr(input logic [4:0] ra,
      input logic [4:0] rb, input logic [4:0] rd, input logic [4:0] sh,
      input logic [5:0] fn);
      return {ABX_OP_SPECIAL, ra, rb, rd, sh, fn};
   endfunction

   // Runs one word at cur_pc and judges every result output
   task automatic exe(input logic [31:0] w, input logic [4:0] fl,
      input logic [31:0] wd, input logic [4:0] wa, input logic [31:0] rpc);
      logic [4:0] got;
      fetch.issue(w, cur_pc, 0);
      got = {wb_en, ovf_exc, redirect, nullify_slot, illegal};
      cmp({31'h0, done}, 32'h1);
      cmp({27'h0, got}, {27'h0, fl});
      if (fl[4]) begin
         cmp({27'h0, wb_addr}, {27'h0, wa});
         cmp(wb_data, wd);
         if (wa != 5'h00) exp_reg[wa] = wd;
      end
      if (fl[3]) cmp(exc_pc, cur_pc);
      if (fl[2]) cmp(redirect_pc, rpc);
      cur_pc = cur_pc + 32'h4;
   endtask

   // Views a register through the idle read port
   task automatic rd_chk(input logic [4:0] idx);
      dbg_rd_addr = idx;
      repeat (3) @(negedge clk);
      cmp(dbg_rd_data, exp_reg[idx]);
   endtask

   task automatic sc_reset();
      cmp({27'h0, wb_en, ovf_exc, redirect, nullify_slot, illegal}, 32'h0);
      rd_chk(5'h00);
   endtask

   task automatic sc_modulo();
      exe(fi(ABX_OP_ADDIM, 0, 1, 16'h8000), F_WB, 32'hffff8000, 1, 0);
      for (int i = 0; i < 16; i++) begin
         exe(fr(1, 1, 1, 0, ABX_FN_ADDRM), F_WB, exp_reg[1] + exp_reg[1],
             1, 0);
      end
      rd_chk(5'h01);
      exe(fi(ABX_OP_ADDIM, 1, 2, 16'hffff), F_WB, 32'h7fffffff, 2, 0);
      exe(fr(2, 2, 7, 0, ABX_FN_ADDRM), F_WB, 32'hfffffffe, 7, 0);
   endtask

   task automatic sc_trap();
      exe(fi(ABX_OP_ADDIM, 0, 3, 16'h0005), F_WB, 32'h5, 3, 0);
      exe(fi(ABX_OP_ADDIT, 3, 3, 16'hfffe), F_WB, 32'h3, 3, 0);
      exe(fi(ABX_OP_ADDIT, 2, 3, 16'h0001), F_OVF, 0, 0, 0);
      exe(fi(ABX_OP_ADDIT, 1, 3, 16'hffff), F_OVF, 0, 0, 0);
      rd_chk(5'h03);
   endtask

   task automatic sc_logic();
      exe(fi(ABX_OP_ADDIM, 0, 5, 16'hf0f0), F_WB, 32'hfffff0f0, 5, 0);
      exe(fr(2, 5, 4, 0, ABX_FN_AND), F_WB, 32'h7ffff0f0, 4, 0);
      exe(fi(ABX_OP_BITAND_IMM, 5, 6, 16'h8ff0), F_WB, 32'h000080f0, 6, 0);
      exe(fr(2, 5, 4, 5'h01, ABX_FN_AND), F_ILL, 0, 0, 0);
      exe(fr(1, 1, 9, 5'h02, ABX_FN_ADDRM), F_ILL, 0, 0, 0);
      exe(fi(ABX_OP_CLASS_A, 5, ABX_RB_NNLINK, 16'h0010), F_ILL, 0, 0,
          0);
      rd_chk(5'h04);
   endtask

   // Harmless non-branch word placed in each delay slot
   // no branch in slot
   task automatic slot_fill();
      exe(fi(ABX_OP_ADDIM, 0, 9, 16'h0001), F_WB, 32'h1, 9, 0);
   endtask

   task automatic sc_branch();
      cur_pc = 32'h00000100;
      exe(fi(ABX_OP_BEQ, 1, 1, 16'hffff), F_RED, 0, 0, 32'h00000100);
      slot_fill();
      exe(fi(ABX_OP_BEQ, 1, 2, 16'h0004), 5'h00, 0, 0, 0);
      slot_fill();
      cur_pc = 32'h00001000;
      exe(fi(ABX_OP_BEQ, 0, 0, 16'h7fff), F_RED, 0, 0, 32'h00021000);
      slot_fill();
      cur_pc = 32'h00040000;
      exe(fi(ABX_OP_BRANCH_IF_EQUAL_LIKELY, 3, 3, 16'h8000), F_RED, 0, 0, 32'h00020004);
      slot_fill();
      exe(fi(ABX_OP_BRANCH_IF_EQUAL_LIKELY, 3, 4, 16'h0001), F_NUL, 0, 0, 0);
      slot_fill();
      cur_pc = 32'h00000200;
      exe(fi(ABX_OP_CLASS_A, 0, ABX_RB_NNLINK, 16'h0010), F_WB | F_RED,
          32'h00000208, 31, 32'h00000244);
      slot_fill();
      rd_chk(5'h1f);
   endtask

   task automatic sc_zero_reg();
      fetch.issue(fi(ABX_OP_ADDIM, 0, 0, 16'h0007), cur_pc, 2);
      rd_chk(5'h00);
      exe(fr(0, 3, 8, 0, ABX_FN_ADDRM), F_WB, 32'h3, 8, 0);
   endtask

   // Main sequence
   initial begin
      clk         = 1'b0;
      rst_n       = 1'b0;
      dbg_rd_addr = 5'h00;
      cur_pc      = 32'h00000100;
      num_errors  = 0;
      n_compared  = 0;
      exp_reg[0]  = 32'h00000000;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      sc_reset();
      sc_modulo();
      sc_trap();
      sc_logic();
      sc_branch();
      sc_zero_reg();
      report_and_stop();
   end

   // Watchdog well beyond the expected run of about 160 cycles
   initial begin
      #50000;
      num_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
